/* File: src/rbg_pkg.sv */
`default_nettype none
// ************************************************************
// register map, fields and state encoding
// ************************************************************
package rbg_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int CNT_W  = 3;

	// byte offsets on the bus
	localparam logic [ADDR_W-1:0] OFF_START      = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_STOP       = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_READY_FLAG = 12'h100;
	localparam logic [ADDR_W-1:0] OFF_AUTO_STOP  = 12'h200;
	localparam logic [ADDR_W-1:0] OFF_IEN_SET    = 12'h304;
	localparam logic [ADDR_W-1:0] OFF_IEN_CLR    = 12'h308;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h400;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 12'h404;
	localparam logic [ADDR_W-1:0] OFF_CONFIG     = 12'h504;
	localparam logic [ADDR_W-1:0] OFF_VALUE      = 12'h508;

	// every single-bit field sits in bit 0
	localparam int FIELD_BIT = 0;

	// reset values
	localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
	localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
	localparam logic              RST_BIT  = 1'h0;

	// byte assembly counter
	localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
	localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;

	typedef enum logic [1:0] {
		RBG_IDLE = 2'h0,
		RBG_RUN  = 2'h1
	} rbg_state_type;

	// state of the bit collector
	typedef struct packed {
		logic [BYTE_W-1:0] shift;
		logic [CNT_W-1:0]  cnt;
		logic              pair_have;
		logic              pair_bit;
	} rbg_asm_type;

	localparam rbg_asm_type ASM_RST = '{shift: 8'h00, cnt: 3'h0, pair_have: 1'h0, pair_bit: 1'h0};
endpackage
`default_nettype wire

/* File: src/rbg_regs.sv */
// Contract
// R1: writing 1 to start trigger begins continuous byte generation; write-only, resets zero.
// R2: writing 1 to stop trigger halts byte generation.
// R3: ready flag set on every new byte; software may read or write it.
// R4: auto-stop bit set makes each ready event trigger stop.
// R5: writing 1 to enable-set enables ready interrupt; reads give enable state.
// R6: writing 1 to enable-clear disables ready interrupt; reads give enable state.
// R7: config bit 0 enables bias correction on raw bits; zero bypasses it.
// R8: bits collected eight at a time into read-only byte in bits 7..0.
// R9: while running every new byte overwrites output, read or not.
// R10: interrupt high while ready flag and its enable are both set.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module rbg_regs (
	input  wire logic                             clk,              // 200 MHz clock
	input  wire logic                             rst,              // sync reset, high
	input  wire logic [rbg_pkg::ADDR_W-1:0]       avs_address,      // byte address
	input  wire logic                             avs_read,         // read request
	input  wire logic                             avs_write,        // write request
	input  wire logic [rbg_pkg::DATA_W-1:0]       avs_writedata,    // write data
	input  wire logic [rbg_pkg::DATA_W/8-1:0]     avs_byteenable,   // byte lanes
	output logic      [rbg_pkg::DATA_W-1:0]       avs_readdata,     // read data
	output logic                                  avs_waitrequest,  // stall
	input  wire logic                             raw_bit,          // entropy bit
	input  wire logic                             raw_valid,        // entropy bit strobe
	output logic                                  running,          // generator active
	output logic                                  irq               // level interrupt
);

	// ************************************************************
	// decode helpers
	// ************************************************************

	// address compare used by every register
	function automatic logic hit(input logic [rbg_pkg::ADDR_W-1:0] a, input logic [rbg_pkg::ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// ************************************************************
	// bus slave
	// ************************************************************

	logic                        ack_reg;
	logic                        ack_next;
	logic [rbg_pkg::DATA_W-1:0]  rdata_reg;
	logic [rbg_pkg::DATA_W-1:0]  rdata_next;
	logic                        req;
	logic                        wr_acc;
	logic                        lane0;
	logic                        wbit;

	rbg_pkg::rbg_state_type      state_reg;
	rbg_pkg::rbg_state_type      state_next;
	rbg_pkg::rbg_asm_type        asm_reg;
	rbg_pkg::rbg_asm_type        asm_next;
	logic [rbg_pkg::BYTE_W-1:0]  value_reg;
	logic [rbg_pkg::BYTE_W-1:0]  value_next;
	logic                        flag_reg;
	logic                        flag_next;
	logic                        auto_stop_reg;
	logic                        auto_stop_next;
	logic                        ien_reg;
	logic                        ien_next;
	logic                        bias_reg;
	logic                        bias_next;

	logic                        start_hit;
	logic                        stop_hit;
	logic                        bit_ok;
	logic                        bit_val;
	logic                        byte_done;
	logic [rbg_pkg::BYTE_W-1:0]  shift_new;

	// one wait state per access; read data is staged in the stall cycle
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_reg;
	assign wr_acc          = avs_write & ack_reg;
	assign lane0           = avs_byteenable[0];
	assign wbit            = avs_writedata[rbg_pkg::FIELD_BIT];
	assign avs_readdata    = rdata_reg;

	// read mux; unmapped and write-only offsets read as zero
	always_comb begin
		ack_next   = req & ~ack_reg;
		rdata_next = rdata_reg;
		if (avs_read && !ack_reg) begin
			rdata_next = rbg_pkg::RST_WORD;
			if (hit(avs_address, rbg_pkg::OFF_READY_FLAG) || hit(avs_address, rbg_pkg::OFF_IRQ_STATUS)) begin
				rdata_next[rbg_pkg::FIELD_BIT] = flag_reg;
			end else if (hit(avs_address, rbg_pkg::OFF_AUTO_STOP)) begin
				rdata_next[rbg_pkg::FIELD_BIT] = auto_stop_reg;
			end else if (hit(avs_address, rbg_pkg::OFF_IEN_SET) || hit(avs_address, rbg_pkg::OFF_IEN_CLR)) begin
				rdata_next[rbg_pkg::FIELD_BIT] = ien_reg; // R5 R6
			end else if (hit(avs_address, rbg_pkg::OFF_CONFIG)) begin
				rdata_next[rbg_pkg::FIELD_BIT] = bias_reg;
			end else if (hit(avs_address, rbg_pkg::OFF_VALUE)) begin
				rdata_next[rbg_pkg::BYTE_W-1:0] = value_reg; // R8
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_reg   <= 1'h0;
			rdata_reg <= rbg_pkg::RST_WORD;
		end else begin
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	// ************************************************************
	// tasks and run state
	// ************************************************************

	assign start_hit = wr_acc & lane0 & wbit & hit(avs_address, rbg_pkg::OFF_START); // R1
	assign stop_hit  = wr_acc & lane0 & wbit & hit(avs_address, rbg_pkg::OFF_STOP);  // R2
	assign running   = (state_reg == rbg_pkg::RBG_RUN);

	// stop, manual or automatic, beats a start in the same cycle
	always_comb begin
		state_next = state_reg;
		if (start_hit) begin
			state_next = rbg_pkg::RBG_RUN; // R1
		end
		if (stop_hit || (byte_done && auto_stop_reg)) begin
			state_next = rbg_pkg::RBG_IDLE; // R2 R4
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= rbg_pkg::RBG_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// bit collector with optional bias correction
	// ************************************************************

	// pairwise debias: 01 gives 0, 10 gives 1, equal pairs are dropped,
	// so corrected output is at best half of the raw rate
	always_comb begin
		asm_next = asm_reg;
		bit_ok   = 1'h0;
		bit_val  = 1'h0;
		if (running && raw_valid) begin
			if (!bias_reg) begin
				bit_ok  = 1'h1; // R7
				bit_val = raw_bit;
			end else if (!asm_reg.pair_have) begin
				asm_next.pair_have = 1'h1;
				asm_next.pair_bit  = raw_bit;
			end else begin
				asm_next.pair_have = 1'h0; // R7
				bit_ok             = (raw_bit != asm_reg.pair_bit);
				bit_val            = asm_reg.pair_bit;
			end
		end
		shift_new = {asm_reg.shift[rbg_pkg::BYTE_W-2:0], bit_val};
		byte_done = bit_ok && (asm_reg.cnt == rbg_pkg::CNT_LAST); // R8
		if (bit_ok) begin
			asm_next.shift = shift_new;
			asm_next.cnt   = asm_reg.cnt + rbg_pkg::CNT_ONE;
		end
		// a partial byte is dropped when stopped so the next run starts clean
		if (!running) begin
			asm_next = rbg_pkg::ASM_RST;
		end
		value_next = byte_done ? shift_new : value_reg; // R9
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			asm_reg   <= rbg_pkg::ASM_RST;
			value_reg <= rbg_pkg::RST_BYTE;
		end else begin
			asm_reg   <= asm_next;
			value_reg <= value_next;
		end
	end

	// ************************************************************
	// flag, shortcut, enable and config registers
	// ************************************************************

	// hardware set wins over a software clear in the same cycle
	always_comb begin
		flag_next      = flag_reg;
		auto_stop_next = auto_stop_reg;
		ien_next       = ien_reg;
		bias_next      = bias_reg;
		if (wr_acc && lane0) begin
			if (hit(avs_address, rbg_pkg::OFF_READY_FLAG)) begin
				flag_next = wbit; // R3
			end
			if (hit(avs_address, rbg_pkg::OFF_IRQ_CLEAR) && wbit) begin
				flag_next = 1'h0;
			end
			if (hit(avs_address, rbg_pkg::OFF_AUTO_STOP)) begin
				auto_stop_next = wbit; // R4
			end
			if (hit(avs_address, rbg_pkg::OFF_IEN_SET) && wbit) begin
				ien_next = 1'h1; // R5
			end
			if (hit(avs_address, rbg_pkg::OFF_IEN_CLR) && wbit) begin
				ien_next = 1'h0; // R6
			end
			if (hit(avs_address, rbg_pkg::OFF_CONFIG)) begin
				bias_next = wbit; // R7
			end
		end
		if (byte_done) begin
			flag_next = 1'h1; // R3
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flag_reg      <= rbg_pkg::RST_BIT;
			auto_stop_reg <= rbg_pkg::RST_BIT;
			ien_reg       <= rbg_pkg::RST_BIT;
			bias_reg      <= rbg_pkg::RST_BIT;
		end else begin
			flag_reg      <= flag_next;
			auto_stop_reg <= auto_stop_next;
			ien_reg       <= ien_next;
			bias_reg      <= bias_next;
		end
	end

	// level interrupt, no pulse stretching
	assign irq = flag_reg & ien_reg; // R10

	// ************************************************************
	// assertions
	// ************************************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_start_runs: assert property (start_hit && !stop_hit && !(byte_done && auto_stop_reg) |=> running) // R1
		else $error("start did not enter run");

	a_stop_halts: assert property (stop_hit |=> !running ##1 !running || start_hit) // R2
		else $error("stop did not halt");

	a_stop_flush: assert property (stop_hit && running |=> ##1 asm_reg == rbg_pkg::ASM_RST) // R2
		else $error("partial byte kept after stop");

	a_flag_sets: assert property (byte_done |=> flag_reg && value_reg == $past(shift_new)) // R3
		else $error("ready flag not set on new byte");

	a_flag_clear: assert property (wr_acc && lane0 && wbit && hit(avs_address, rbg_pkg::OFF_IRQ_CLEAR) // R3
		&& !byte_done |=> !flag_reg)
		else $error("ready flag not cleared");

	a_auto_stop: assert property (byte_done && auto_stop_reg |=> !running) // R4
		else $error("auto stop failed");

	a_no_auto_stop: assert property (byte_done && !auto_stop_reg && !stop_hit |=> running) // R4
		else $error("stopped without shortcut");

	a_ien_set: assert property (wr_acc && lane0 && wbit && hit(avs_address, rbg_pkg::OFF_IEN_SET) |=> ien_reg) // R5
		else $error("enable set failed");

	a_ien_clr: assert property (wr_acc && lane0 && wbit && hit(avs_address, rbg_pkg::OFF_IEN_CLR) |=> !ien_reg) // R6
		else $error("enable clear failed");

	a_bias_drop: assert property (running && bias_reg && raw_valid && asm_reg.pair_have // R7
		&& raw_bit == asm_reg.pair_bit |=> asm_reg.cnt == $past(asm_reg.cnt))
		else $error("equal pair not dropped");

	a_bias_take: assert property (running && bias_reg && raw_valid && asm_reg.pair_have // R7
		&& raw_bit != asm_reg.pair_bit && !stop_hit && !(byte_done && auto_stop_reg)
		|=> asm_reg.cnt == $past(asm_reg.cnt) + rbg_pkg::CNT_ONE)
		else $error("unequal pair not collected");

	a_bypass_count: assert property (running && !bias_reg && raw_valid && !stop_hit // R7
		&& !(byte_done && auto_stop_reg) |=> asm_reg.cnt == $past(asm_reg.cnt) + rbg_pkg::CNT_ONE)
		else $error("raw bit not collected");

	// data was staged in the stall cycle, so a byte landing then is not yet visible
	a_value_read: assert property (avs_read && ack_reg && hit(avs_address, rbg_pkg::OFF_VALUE) // R8
		|-> avs_readdata == {24'h000000, $past(value_reg)})
		else $error("value read mismatch");

	a_idle_hold: assert property (!running && !byte_done |=> $stable(value_reg)) // R9
		else $error("value changed while idle");

	a_irq_level: assert property (flag_reg && ien_reg |-> irq) // R10
		else $error("interrupt missing");

	a_irq_drop: assert property ($fell(flag_reg) |-> !irq) // R10
		else $error("interrupt stuck after clear");

	c_start: cover property (start_hit ##[1:50] byte_done);
	c_auto_stop: cover property (byte_done && auto_stop_reg);
	c_irq_bias: cover property (irq && bias_reg);
	c_value_read: cover property (avs_read && ack_reg && hit(avs_address, rbg_pkg::OFF_VALUE));

endmodule // rbg_regs
`default_nettype wire

/* File: bench/rbg_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// bench for the random byte generator registers
// ************************************************************
module rbg_regs_tb;
	logic        clk = 1'b0;
	logic        rst;
	logic [11:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        raw_bit;
	logic        raw_valid;
	logic        running;
	logic        irq;
	int          num_errors = 0;
	int          num_checks = 0;
	// reference state kept in plain integers
	int          m_run, m_sh, m_cnt, m_ph, m_pb, m_val, m_flag, m_auto, m_ien, m_bias;

	rbg_regs i_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .raw_bit(raw_bit),
		.raw_valid(raw_valid), .running(running), .irq(irq));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// ************************************************************
	// verdict and comparison
	// ************************************************************
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ************************************************************
	// reference model
	// ************************************************************
	function automatic logic [31:0] m_read(input logic [11:0] a);
		case (a)
			12'h100, 12'h400: return m_flag;
			12'h200:          return m_auto;
			12'h304, 12'h308: return m_ien;
			12'h504:          return m_bias;
			12'h508:          return m_val;
			default:          return 32'h0000_0000;
		endcase
	endfunction

	// a stop always drops the partial byte so the next byte is clean
	task automatic m_wr(input logic [11:0] a, input int d);
		case (a)
			12'h000: if (d) m_run = 1;
			12'h004: if (d) begin m_run = 0; m_cnt = 0; m_ph = 0; end
			12'h100: m_flag = d;
			12'h200: m_auto = d;
			12'h304: if (d) m_ien = 1;
			12'h308: if (d) m_ien = 0;
			12'h404: if (d) m_flag = 0;
			12'h504: m_bias = d;
			default: ;
		endcase
	endtask

	task automatic m_bit(input int b);
		int take, v;
		take = 1;
		v = b;
		if (m_run == 0) return;
		if (m_bias != 0) begin
			take = m_ph && (m_pb != b);
			v = m_pb;
			m_pb = b;
			m_ph = !m_ph;
		end
		if (take) begin
			m_sh = ((m_sh << 1) | v) & 255;
			m_cnt++;
			if (m_cnt == 8) begin
				m_val = m_sh;
				m_flag = 1;
				m_cnt = 0;
				if (m_auto) begin m_run = 0; m_ph = 0; end
			end
		end
	endtask

	// ************************************************************
	// bus and entropy drivers
	// ************************************************************
	// waitrequest and read data are looked at on rising edges only; a hang is left to the watchdog
	task automatic wait_ack(output logic [31:0] q);
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		q = avs_readdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
		logic [31:0] q;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		wait_ack(q);
		avs_write <= 1'b0;
		avs_writedata <= ~d;
		if (be[0]) m_wr(a, d[0]);
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a);
		logic [31:0] q;
		avs_address <= a;
		avs_read <= 1'b1;
		wait_ack(q);
		avs_read <= 1'b0;
		avs_address <= ~a;
		chk(q, m_read(a));
		@(posedge clk);
	endtask

	// raw_valid held across the burst, so no strobe is written twice in one step
	task automatic feed(input int n);
		logic b;
		for (int i = 0; i < n; i++) begin
			b = $urandom % 2;
			raw_bit <= b;
			raw_valid <= 1'b1;
			@(posedge clk);
			m_bit(b);
		end
		raw_valid <= 1'b0;
		raw_bit <= ~b;
		@(posedge clk);
	endtask

	// readback of every mapped place plus an unmapped one
	task automatic state();
		logic [11:0] offs [11] = '{12'h000, 12'h004, 12'h100, 12'h200, 12'h304, 12'h308,
			12'h400, 12'h404, 12'h504, 12'h508, 12'h0FC};
		chk(irq, m_flag & m_ien);
		chk(running, m_run);
		foreach (offs[i]) rd(offs[i]);
	endtask

	// ************************************************************
	// watchdog and main sequence
	// ************************************************************
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_sim();
	end

	initial begin
		void'($urandom(37554));
		{m_run, m_sh, m_cnt, m_ph, m_pb, m_val, m_flag, m_auto, m_ien, m_bias} = '0;
		rst <= 1'b1;
		{avs_read, avs_write, raw_bit, raw_valid} <= 4'h0;
		avs_address <= 12'h000;
		avs_writedata <= 32'h0000_0000;
		avs_byteenable <= 4'hF;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		state();
		feed(8);
		state();
		wr(12'h304, 32'h0000_0000);
		wr(12'h304, 32'h0000_0001);
		wr(12'h308, 32'h0000_0000);
		wr(12'h200, 32'h0000_0001, 4'hE);
		state();
		wr(12'h000, 32'h0000_0001);
		feed(8);
		state();
		feed(8);
		feed(8);
		state();
		wr(12'h100, 32'h0000_0000);
		wr(12'h308, 32'h0000_0001);
		feed(8);
		state();
		wr(12'h404, 32'h0000_0001);
		wr(12'h304, 32'h0000_0001);
		feed(3);
		wr(12'h004, 32'h0000_0001);
		feed(8);
		state();
		wr(12'h504, 32'h0000_0001);
		wr(12'h000, 32'h0000_0001);
		feed(5);
		feed(48);
		state();
		wr(12'h004, 32'h0000_0001);
		wr(12'h504, 32'h0000_0000);
		wr(12'h200, 32'h0000_0001);
		wr(12'h000, 32'h0000_0001);
		feed(13);
		state();
		wr(12'h000, 32'h0000_0001);
		feed(20);
		state();
		// reset in mid-run, with a partial byte and a pending interrupt
		wr(12'h000, 32'h0000_0001);
		feed(5);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		{m_run, m_sh, m_cnt, m_ph, m_pb, m_val, m_flag, m_auto, m_ien, m_bias} = '0;
		@(posedge clk);
		state();
		end_sim();
	end
endmodule // rbg_regs_tb
`default_nettype wire
